// File: ccr_core_regs.sv
// core control registers, banked data memory and analog pin gating
`timescale 1ns/1ns
// How it works
// - two bank select bits pick one of four banks for direct access
// - each bank is a 128-byte window, offsets 00h to 7Fh
// - low offsets decode to special registers, higher ones to ram up to 7Fh in bank 0 and 6Fh in banks 1 and 2
// - some special registers answer at one offset in several banks
// - 256 bytes of ram, reached directly or through the pointer
// - option register is read/write and resets to all ones
// - option bit 7 set kills all pull-ups, else per-pin enables
// - option bit 6 picks rising (1) or falling (0) irq edge
// - option bit 5 picks external pin or instruction clock for timer
// - option bit 4 set counts falling edges of external clock
// - option bit 3 gives the prescaler to watchdog, else timer
// - rate field divides timer 2..256 or watchdog 1..128
// - timer runs undivided while the prescaler serves the watchdog
// - power-on reset clears the power-on flag until software sets it
// - brown-out reset clears the brown-out flag; software sets it
// - software brown-out enable acts only when config mode is 01
// - analog select register, eight bits reset to one
// - digital reads of an analog-selected pin return zero
// - analog selection leaves the digital output path untouched
// - analog mode kills input buffer, pull-up and change interrupt
// - a pull-up switches off while its pin is an output
module ccr_core_regs #(
    parameter int PINS = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [ccr_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic [ccr_pkg::BANK_W-1:0] bank_sel,
    input wire logic por_event,
    input wire logic brownout_event,
    input wire logic [1:0] cfg_brownout_mode,
    output logic brownout_detect_en,
    output ccr_pkg::ccr_timer_cfg_type timer_cfg,
    input wire logic [7:0] pullup_pin_enables,
    input wire logic [7:0] pin_direction,
    output logic [7:0] pullup_active,
    input wire logic [PINS-1:0] analog_pin_in,
    input wire logic [PINS-1:0] analog_pin_latch,
    input wire logic [PINS-1:0] analog_pin_direction,
    output logic [PINS-1:0] analog_pin_digital,
    output logic [PINS-1:0] analog_pin_out,
    output logic [PINS-1:0] analog_pin_oe,
    output logic [PINS-1:0] digital_in_buf_en,
    output logic [PINS-1:0] analog_pullup_allow,
    output logic [PINS-1:0] change_irq_allow
);
    // ram slot of a linear address, valid flag in the top bit
    function automatic logic [8:0] gpr_slot(
        input logic [ccr_pkg::LIN_W-1:0] lin
    );
        logic [6:0] ofs;
        logic [7:0] rel;
        ofs = lin[6:0];
        rel = {1'b0, ofs - ccr_pkg::GPR_BASE};
        gpr_slot = 9'h000;
        if (ofs >= ccr_pkg::GPR_BASE) begin
            unique case (lin[8:7])
                2'h0: gpr_slot = {1'b1, rel};
                2'h1: gpr_slot = {ofs <= ccr_pkg::GPR_TOP_B12,
                                  rel + ccr_pkg::GPR_IDX_B1};
                2'h2: gpr_slot = {ofs <= ccr_pkg::GPR_TOP_B12,
                                  rel + ccr_pkg::GPR_IDX_B2};
                2'h3: gpr_slot = 9'h000;
            endcase
        end
    endfunction

    logic [7:0] gpr_mem [ccr_pkg::GPR_DEPTH];
    logic [7:0] bank_ctrl;
    logic [7:0] next_bank_ctrl;
    logic [7:0] pointer;
    logic [7:0] next_pointer;
    logic [7:0] option;
    logic [7:0] next_option;
    logic [7:0] analog_select_bits;
    logic [7:0] next_analog_select_bits;
    logic sw_brownout_enable;
    logic next_sw_brownout_enable;
    logic por_flag;
    logic next_por_flag;
    logic brownout_flag;
    logic next_brownout_flag;
    logic [7:0] next_mem_rdata;
    logic [ccr_pkg::LIN_W-1:0] lin_addr;
    logic [8:0] slot;
    logic is_option;
    logic is_power;
    logic is_analog;
    logic is_bank;
    logic is_pointer;
    logic [7:0] power_word;
    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;

    // direct offsets take the bank bits, indirect uses irp and pointer
    assign lin_addr = (mem_addr == ccr_pkg::OFS_INDIRECT_DATA) ?
        {bank_ctrl[ccr_pkg::BC_IRP], pointer} :
        {bank_sel, mem_addr};
    assign bank_sel = {bank_ctrl[ccr_pkg::BC_SEL_HI],
                       bank_ctrl[ccr_pkg::BC_SEL_LO]};
    assign slot = gpr_slot(lin_addr);
    // special register decode, bank and pointer appear in every bank
    always_comb begin
        is_bank = (lin_addr[6:0] == ccr_pkg::OFS_BANK_CTRL);
        is_pointer = (lin_addr[6:0] == ccr_pkg::OFS_POINTER);
        is_option = (lin_addr[6:0] == ccr_pkg::OFS_OPTION) &&
            (lin_addr[8:7] == ccr_pkg::BANK_OPTION_A ||
             lin_addr[8:7] == ccr_pkg::BANK_OPTION_B);
        is_power = (lin_addr[6:0] == ccr_pkg::OFS_POWER) &&
            (lin_addr[8:7] == ccr_pkg::BANK_POWER);
        is_analog = (lin_addr[6:0] == ccr_pkg::OFS_ANALOG) &&
            (lin_addr[8:7] == ccr_pkg::BANK_ANALOG);
    end

    // power register image, unused bits read zero
    always_comb begin
        power_word = 8'h00;
        power_word[ccr_pkg::PWR_SW_BROWNOUT_ENABLE] = sw_brownout_enable;
        power_word[ccr_pkg::PWR_POR] = por_flag;
        power_word[ccr_pkg::PWR_BOR] = brownout_flag;
    end

    // register writes; hardware reset events beat a software write
    always_comb begin
        next_bank_ctrl = bank_ctrl;
        next_pointer = pointer;
        next_option = option;
        next_analog_select_bits = analog_select_bits;
        next_sw_brownout_enable = sw_brownout_enable;
        next_por_flag = por_flag;
        next_brownout_flag = brownout_flag;
        if (mem_wr) begin
            if (is_bank) begin
                next_bank_ctrl = mem_wdata & ccr_pkg::BC_MASK;
            end
            if (is_pointer) begin
                next_pointer = mem_wdata;
            end
            if (is_option) begin
                next_option = mem_wdata;
            end
            if (is_analog) begin
                next_analog_select_bits = mem_wdata;
            end
            if (is_power) begin
                next_sw_brownout_enable = mem_wdata[ccr_pkg::PWR_SW_BROWNOUT_ENABLE];
                next_por_flag = mem_wdata[ccr_pkg::PWR_POR];
                next_brownout_flag = mem_wdata[ccr_pkg::PWR_BOR];
            end
        end
        if (por_event) begin
            next_por_flag = 1'b0;
            next_brownout_flag = 1'b0;
        end
        if (brownout_event) begin
            next_brownout_flag = 1'b0;
        end
    end

    // register state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_ctrl <= ccr_pkg::RST_BANK_CTRL;
            pointer <= ccr_pkg::RST_POINTER;
            option <= ccr_pkg::RST_OPTION;
            analog_select_bits <= ccr_pkg::RST_ANALOG;
            sw_brownout_enable <= ccr_pkg::RST_SW_BROWNOUT_ENABLE;
            por_flag <= ccr_pkg::RST_POR;
            brownout_flag <= ccr_pkg::RST_BOR;
        end else begin
            bank_ctrl <= next_bank_ctrl;
            pointer <= next_pointer;
            option <= next_option;
            analog_select_bits <= next_analog_select_bits;
            sw_brownout_enable <= next_sw_brownout_enable;
            por_flag <= next_por_flag;
            brownout_flag <= next_brownout_flag;
        end
    end

    // ram array, written in the cycle of the access
    always_ff @(posedge clk) begin
        if (mem_wr && slot[8]) begin
            gpr_mem[slot[7:0]] <= mem_wdata;
        end
    end

    // read data, one cycle after the read strobe
    always_comb begin
        next_mem_rdata = mem_rdata;
        if (mem_rd) begin
            next_mem_rdata = 8'h00;
            if (slot[8]) begin
                next_mem_rdata = gpr_mem[slot[7:0]];
            end else if (is_bank) begin
                next_mem_rdata = bank_ctrl;
            end else if (is_pointer) begin
                next_mem_rdata = pointer;
            end else if (is_option) begin
                next_mem_rdata = option;
            end else if (is_power) begin
                next_mem_rdata = power_word;
            end else if (is_analog) begin
                next_mem_rdata = analog_select_bits;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_rdata <= 8'h00;
        end else begin
            mem_rdata <= next_mem_rdata;
        end
    end

    // pin level synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= analog_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // analog pin gating
    assign analog_pin_digital = pin_sync & ~analog_select_bits[PINS-1:0];
    assign analog_pin_out = analog_pin_latch;
    assign analog_pin_oe = ~analog_pin_direction;
    assign digital_in_buf_en = ~analog_select_bits[PINS-1:0];
    assign analog_pullup_allow = ~analog_select_bits[PINS-1:0];
    assign change_irq_allow = ~analog_select_bits[PINS-1:0];

    // port b pull-ups: global kill, per-pin enable, inputs only
    assign pullup_active = option[ccr_pkg::OPT_PULLUP_DIS] ? 8'h00 :
        (pullup_pin_enables & pin_direction);

    // brown-out detect: 00 off, 01 software bit, otherwise on
    always_comb begin
        if (cfg_brownout_mode == ccr_pkg::BOD_SOFT) begin
            brownout_detect_en = sw_brownout_enable;
        end else begin
            brownout_detect_en = (cfg_brownout_mode != ccr_pkg::BOD_OFF);
        end
    end

    // timer and watchdog configuration from the option register
    always_comb begin
        timer_cfg.ext_irq_edge_sel = option[ccr_pkg::OPT_IRQ_EDGE];
        timer_cfg.timer_zero_clk_source = option[ccr_pkg::OPT_CLK_SRC];
        timer_cfg.timer_zero_edge_sel = option[ccr_pkg::OPT_EDGE_SEL];
        timer_cfg.prescaler_assign = option[ccr_pkg::OPT_PS_ASSIGN];
        if (option[ccr_pkg::OPT_PS_ASSIGN]) begin
            timer_cfg.timer_zero_div_log2 = 4'h0;
            timer_cfg.watchdog_div_log2 =
                {1'b0, option[ccr_pkg::OPT_RATE_HI:0]};
        end else begin
            timer_cfg.timer_zero_div_log2 =
                {1'b0, option[ccr_pkg::OPT_RATE_HI:0]} + 4'h1;
            timer_cfg.watchdog_div_log2 = 4'h0;
        end
    end
    // checks
    property p_option_write;
        @(posedge clk) disable iff (rst)
        (mem_wr && is_option && !mem_rd) |=> (option == $past(mem_wdata));
    endproperty
    a_option_write: assert property (p_option_write)
        else $error("option write lost");
    property p_pullup_kill;
        @(posedge clk) disable iff (rst)
        option[7] |-> (pullup_active == 8'h00);
    endproperty
    a_pullup_kill: assert property (p_pullup_kill)
        else $error("pull-up on while globally disabled");
    property p_pullup_output;
        @(posedge clk) disable iff (rst)
        (pullup_active & ~pin_direction) == 8'h00;
    endproperty
    a_pullup_output: assert property (p_pullup_output)
        else $error("pull-up on an output pin");
    property p_timer_div;
        @(posedge clk) disable iff (rst)
        !option[3] |-> (timer_cfg.timer_zero_div_log2 ==
            {1'b0, option[2:0]} + 4'h1) && timer_cfg.watchdog_div_log2 == 0;
    endproperty
    a_timer_div: assert property (p_timer_div)
        else $error("timer divide wrong");
    property p_timer_undivided;
        @(posedge clk) disable iff (rst)
        option[3] |-> timer_cfg.timer_zero_div_log2 == 4'h0;
    endproperty
    a_timer_undivided: assert property (p_timer_undivided)
        else $error("timer divided while prescaler serves watchdog");
    property p_por_clear;
        @(posedge clk) disable iff (rst)
        por_event |=> !por_flag && !brownout_flag;
    endproperty
    a_por_clear: assert property (p_por_clear)
        else $error("power-on flag not cleared");
    property p_bor_clear;
        @(posedge clk) disable iff (rst)
        brownout_event |=> !brownout_flag;
    endproperty
    a_bor_clear: assert property (p_bor_clear)
        else $error("brown-out flag not cleared");
    property p_bod_soft;
        @(posedge clk) disable iff (rst)
        (cfg_brownout_mode == 2'h1) |-> brownout_detect_en == power_word[4];
    endproperty
    a_bod_soft: assert property (p_bod_soft)
        else $error("software brown-out enable ignored");
    property p_analog_read;
        @(posedge clk) disable iff (rst)
        (analog_pin_digital & analog_select_bits[PINS-1:0]) == '0;
    endproperty
    a_analog_read: assert property (p_analog_read)
        else $error("analog pin read non-zero");
    property p_power_read;
        @(posedge clk) disable iff (rst)
        (mem_rd && is_power && !slot[8]) |=>
            (mem_rdata & ~ccr_pkg::PWR_MASK) == 8'h00;
    endproperty
    a_power_read: assert property (p_power_read)
        else $error("unused power bits read non-zero");
    c_option_write: cover property (@(posedge clk) disable iff (rst)
        mem_wr && is_option);
    c_indirect_ram: cover property (@(posedge clk) disable iff (rst)
        mem_rd && mem_addr == 7'h00 && slot[8]);
    c_bank3_mirror: cover property (@(posedge clk) disable iff (rst)
        mem_rd && is_option && bank_sel == 2'h3);
endmodule

// File: ccr_pkg.sv
// shared constants and types of the core control register block
package ccr_pkg;
    // data memory geometry
    localparam int ADDR_W = 7;
    localparam int BANK_W = 2;
    localparam int LIN_W = 9;
    localparam int GPR_DEPTH = 256;
    localparam logic [6:0] BANK_TOP = 7'h7F;
    localparam logic [6:0] GPR_BASE = 7'h20;
    localparam logic [6:0] GPR_TOP_B0 = 7'h7F;
    localparam logic [6:0] GPR_TOP_B12 = 7'h6F;
    localparam logic [7:0] GPR_IDX_B1 = 8'h60;
    localparam logic [7:0] GPR_IDX_B2 = 8'hB0;
    // special function offsets
    localparam logic [6:0] OFS_INDIRECT_DATA = 7'h00;
    localparam logic [6:0] OFS_OPTION = 7'h01;
    localparam logic [6:0] OFS_BANK_CTRL = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_POWER = 7'h0E;
    localparam logic [6:0] OFS_ANALOG = 7'h11;
    localparam logic [1:0] BANK_OPTION_A = 2'h1;
    localparam logic [1:0] BANK_OPTION_B = 2'h3;
    localparam logic [1:0] BANK_POWER = 2'h1;
    localparam logic [1:0] BANK_ANALOG = 2'h1;
    // bank control field positions
    localparam int BC_IRP = 7;
    localparam int BC_SEL_HI = 6;
    localparam int BC_SEL_LO = 5;
    localparam logic [7:0] BC_MASK = 8'hE0;
    // option register fields
    localparam int OPT_PULLUP_DIS = 7;
    localparam int OPT_IRQ_EDGE = 6;
    localparam int OPT_CLK_SRC = 5;
    localparam int OPT_EDGE_SEL = 4;
    localparam int OPT_PS_ASSIGN = 3;
    localparam int OPT_RATE_HI = 2;
    // power register fields
    localparam int PWR_SW_BROWNOUT_ENABLE = 4;
    localparam int PWR_POR = 1;
    localparam int PWR_BOR = 0;
    localparam logic [7:0] PWR_MASK = 8'h13;
    // reset values
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] RST_ANALOG = 8'hFF;
    localparam logic [7:0] RST_BANK_CTRL = 8'h00;
    localparam logic [7:0] RST_POINTER = 8'h00;
    localparam logic RST_SW_BROWNOUT_ENABLE = 1'b1;
    localparam logic RST_POR = 1'b0;
    localparam logic RST_BOR = 1'b0;
    // configuration word brown-out modes
    localparam logic [1:0] BOD_OFF = 2'h0;
    localparam logic [1:0] BOD_SOFT = 2'h1;
    // timer and watchdog settings, divide ratios as log2
    typedef struct packed {
        logic ext_irq_edge_sel;
        logic timer_zero_clk_source;
        logic timer_zero_edge_sel;
        logic prescaler_assign;
        logic [3:0] timer_zero_div_log2;
        logic [3:0] watchdog_div_log2;
    } ccr_timer_cfg_type;
endpackage

// File: tb_ccr_core_regs.sv
// self-checking bench for the core control register block
`timescale 1ns/1ns
module tb_ccr_core_regs;
    logic clk, rst, mem_rd, mem_wr, rd_seen;
    logic [ccr_pkg::ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, pu_en, pin_dir_b, pu_act, v;
    logic [ccr_pkg::BANK_W-1:0] bank_sel;
    logic por_event, brownout_event, bod_en, e;
    logic [1:0] bod_mode;
    ccr_pkg::ccr_timer_cfg_type timer_cfg;
    logic [7:0] pin_in, pin_latch, pin_dir, pin_dig, pin_out, pin_oe;
    logic [7:0] buf_en, pu_allow, ioc_allow;
    logic [31:0] seed, r;
    logic [7:0] exp_q[$];
    logic [7:0] d[6];
    logic [1:0] bk[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [6:0] of[6] = '{7'h20, 7'h7F, 7'h20, 7'h6F, 7'h20, 7'h6F};
    int errors;
    int cmp_count;

    ccr_core_regs #(.PINS(8)) i_dut (
        .clk(clk), .rst(rst), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .bank_sel(bank_sel), .por_event(por_event),
        .brownout_event(brownout_event), .cfg_brownout_mode(bod_mode),
        .brownout_detect_en(bod_en), .timer_cfg(timer_cfg),
        .pullup_pin_enables(pu_en), .pin_direction(pin_dir_b),
        .pullup_active(pu_act), .analog_pin_in(pin_in),
        .analog_pin_latch(pin_latch), .analog_pin_direction(pin_dir),
        .analog_pin_digital(pin_dig), .analog_pin_out(pin_out),
        .analog_pin_oe(pin_oe), .digital_in_buf_en(buf_en),
        .analog_pullup_allow(pu_allow), .change_irq_allow(ioc_allow));

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected timer settings from an option value
    function automatic logic [11:0] cfg_exp(input logic [7:0] o);
        return {o[6], o[5], o[4], o[3],
                o[3] ? 4'h0 : {1'b0, o[2:0]} + 4'h1,
                o[3] ? {1'b0, o[2:0]} : 4'h0};
    endfunction

    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one register access, strobe up for exactly one edge
    task automatic acc(input logic rd, input logic wr, input logic [6:0] a,
                       input logic [7:0] wd);
        @(posedge clk);
        mem_rd <= rd;
        mem_wr <= wr;
        mem_addr <= a;
        mem_wdata <= wd;
        @(posedge clk);
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] wd);
        acc(1'b0, 1'b1, a, wd);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        acc(1'b1, 1'b0, a, 8'h00);
    endtask

    task automatic bank(input logic [1:0] b);
        wr(ccr_pkg::OFS_BANK_CTRL, {1'b0, b, 5'h00});
    endtask

    task automatic pulse(input logic por);
        @(posedge clk);
        if (por) begin
            por_event <= 1'b1;
        end else begin
            brownout_event <= 1'b1;
        end
        @(posedge clk);
        por_event <= 1'b0;
        brownout_event <= 1'b0;
    endtask

    // read result watcher, data lands the edge after the strobe
    always @(posedge clk) rd_seen <= mem_rd & ~rst;
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("[FAIL] t=%0t got=%h exp=none", $time, mem_rdata);
            end else begin
                compare(16'(mem_rdata), 16'(exp_q.pop_front()));
            end
        end
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("run limit reached");
        end_of_test();
    end

    initial begin
        seed = 32'h0000CD24;
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        {mem_rd, mem_wr, por_event, brownout_event} = 4'h0;
        mem_addr = 7'h00;
        mem_wdata = 8'h00;
        bod_mode = 2'h0;
        {pu_en, pin_dir_b, pin_in, pin_latch, pin_dir} = 40'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        compare(16'(pu_act), 16'h0000);
        compare(16'(timer_cfg), 16'(cfg_exp(8'hFF)));
        bank(2'h1);
        rd(ccr_pkg::OFS_OPTION, 8'hFF);
        rd(ccr_pkg::OFS_POWER, 8'h10);
        rd(ccr_pkg::OFS_ANALOG, 8'hFF);
        $display("reset values test done");
        // option fields, every rate with both prescaler owners
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            v = {r[7:4], i[3:0]};
            @(posedge clk);
            pu_en <= r[15:8];
            pin_dir_b <= r[23:16];
            bank(i[0] ? 2'h1 : 2'h3);
            wr(ccr_pkg::OFS_OPTION, v);
            bank(i[0] ? 2'h3 : 2'h1);
            rd(ccr_pkg::OFS_OPTION, v);
            @(negedge clk);
            compare(16'(timer_cfg), 16'(cfg_exp(v)));
            compare(16'(pu_act), 16'(v[7] ? 8'h00 : r[15:8] & r[23:16]));
        end
        $display("option test done");
        // power flags, events and brown-out enable
        bank(2'h1);
        wr(ccr_pkg::OFS_POWER, 8'hFF);
        rd(ccr_pkg::OFS_POWER, 8'h13);
        pulse(1'b0);
        rd(ccr_pkg::OFS_POWER, 8'h12);
        pulse(1'b1);
        rd(ccr_pkg::OFS_POWER, 8'h10);
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            bod_mode <= m[1:0];
            wr(ccr_pkg::OFS_POWER, {3'h0, m[2], 4'h3});
            @(negedge clk);
            e = (m[1:0] == 2'h0) ? 1'b0 : (m[1:0] == 2'h1) ? m[2] : 1'b1;
            compare(16'(bod_en), 16'(e));
        end
        $display("power test done");
        // ram in banks 0 to 2, direct and through the pointer
        for (int k = 0; k < 6; k++) begin
            d[k] = 8'(rnd());
            bank(bk[k]);
            wr(of[k], d[k]);
            compare(16'(bank_sel), 16'(bk[k]));
        end
        for (int k = 5; k >= 0; k--) begin
            bank(bk[k]);
            rd(of[k], d[k]);
        end
        bank(2'h3);
        rd(7'h20, 8'h00);
        bank(2'h1);
        rd(7'h70, 8'h00);
        wr(ccr_pkg::OFS_POINTER, 8'h20);
        rd(ccr_pkg::OFS_INDIRECT_DATA, d[0]);
        wr(ccr_pkg::OFS_POINTER, 8'hEF);
        rd(ccr_pkg::OFS_INDIRECT_DATA, d[3]);
        wr(ccr_pkg::OFS_BANK_CTRL, 8'hFF);
        rd(ccr_pkg::OFS_BANK_CTRL, 8'hE0);
        compare(16'(bank_sel), 16'h0003);
        wr(ccr_pkg::OFS_POINTER, 8'h20);
        rd(ccr_pkg::OFS_INDIRECT_DATA, d[4]);
        $display("banking test done");
        // analog select gating of the pins
        bank(2'h1);
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : r[7:0];
            @(posedge clk);
            pin_in <= r[15:8];
            pin_latch <= r[23:16];
            pin_dir <= r[31:24];
            wr(ccr_pkg::OFS_ANALOG, v);
            rd(ccr_pkg::OFS_ANALOG, v);
            repeat (2) @(posedge clk);
            @(negedge clk);
            compare(16'(pin_dig), 16'(r[15:8] & ~v));
            compare({pin_out, pin_oe}, {r[23:16], ~r[31:24]});
            compare({buf_en, pu_allow}, {~v, ~v});
            compare(16'(ioc_allow), {8'h00, ~v});
        end
        $display("analog test done");
        // mid-run reset brings the registers back to their reset values
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        compare(16'(bank_sel), 16'h0000);
        bank(2'h1);
        rd(ccr_pkg::OFS_OPTION, 8'hFF);
        rd(ccr_pkg::OFS_ANALOG, 8'hFF);
        $display("mid-run reset test done");
        repeat (2) @(posedge clk);
        if (exp_q.size() != 0) begin
            errors++;
        end
        end_of_test();
    end
endmodule
